// ===== common/sasr_pkg.sv
package sasr_pkg;
    // Clock rate of clk in MHz
    localparam int CLK_MHZ = 125;
    // Longest conversion_time per conversion mode, in ns (plain defaults)
    localparam int CONV_NORMAL_NS = 400;
    localparam int CONV_TURBO_NS  = 320;
    // Cycle counts, rounded up so a conversion is never cut short
    localparam int CONV_NORMAL_CYC = (CONV_NORMAL_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_TURBO_CYC  = (CONV_TURBO_NS * CLK_MHZ + 999) / 1000;
    // Result width and shift lengths
    localparam int RES_W      = 14;
    localparam int SHIFT_BITS = 14;
    localparam int BUSY_BITS  = 15;
    // Level driven as the busy start bit
    localparam logic BUSY_START = 1'b0;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    // Control fields and reset values
    localparam int   CTRL_FAST_BIT = 0;
    localparam logic CTRL_FAST_RST = 1'b0;
    // Status fields
    localparam int STS_CHAIN_BIT = 0;
    localparam int STS_BUSY_BIT  = 1;
    localparam int STS_CONV_BIT  = 2;
    localparam int STS_MERR_BIT  = 3;
    localparam int STS_ACQ_BIT   = 4;
    // AHB word transfer size
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Bit positions of the pins in the synchroniser vector
    localparam int PIN_STROBE = 0;
    localparam int PIN_CASC   = 1;
    localparam int PIN_SCK    = 2;

    // Pins from the host
    typedef struct packed {
        logic shiftClk;
        logic cascade;
        logic strobe;
    } sasr_pins_t;

    // Serial output pin: enable and level
    typedef struct packed {
        logic oe;
        logic data;
    } sasr_sdo_t;

    // Serial output sequencer states
    typedef enum logic [1:0] {
        SO_IDLE  = 2'h0,
        SO_SEL   = 2'h1,
        SO_BUSY  = 2'h3,
        SO_CHAIN = 2'h2
    } sasr_so_state_t;
endpackage

// ===== hw/sasr_convert.sv
`timescale 1ns/10ps
module sasr_convert (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             start,
    input  wire logic             fastRate,
    input  wire logic [13:0]      sampleIn,
    output logic                  busy,
    output logic                  done,
    output logic      [13:0]      result
);
    import sasr_pkg::*;

    logic [6:0]  cntQ;    // Cycles left in this conversion
    logic [13:0] heldQ;   // Value caught at the sampling instant

    // Conversion timer; a start while busy is ignored
    always_ff @(posedge clk) begin
        if (srst) begin
            busy  <= 1'b0;
            done  <= 1'b0;
            cntQ  <= 7'h00;
            heldQ <= 14'h0000;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy  <= 1'b1;
                heldQ <= sampleIn;
                cntQ  <= fastRate ? 7'(CONV_TURBO_CYC - 1)
                                  : 7'(CONV_NORMAL_CYC - 1);
            end else if (busy) begin
                if (cntQ == 7'h00) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cntQ <= cntQ - 7'h01;
                end
            end
        end
    end

    // Result only changes at completion, so reads in between see n-1
    always_ff @(posedge clk) begin
        if (srst) begin
            result <= 14'h0000;
        end else if (busy && cntQ == 7'h00) begin
            result <= heldQ;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_result_at_done: assert property (
        $changed(result) |-> done)
        else $error("result changed outside conversion completion");
endmodule

// ===== hw/sasr_readout.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module sasr_readout (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire sasr_pkg::sasr_pins_t pinsIn,
    input  wire logic [13:0]          sampleIn,
    output sasr_pkg::sasr_sdo_t       sdoOut,
    output logic                      convActive
);
    import sasr_pkg::*;

    // Synchronised pin levels and edges
    logic [2:0]  pinLvl;
    logic [2:0]  pinRise;
    logic [2:0]  pinFall;
    logic        strobeLvl;     // Convert strobe level
    logic        strobeRise;    // Convert strobe rising
    logic        cascLvl;       // Cascade input level
    logic        sckFall;       // Shift clock falling
    logic        cascPrevQ;     // Cascade level one cycle earlier
    // Conversion engine
    logic        convStart;     // Accepted conversion start
    logic        convDone;      // One-cycle completion pulse
    logic [13:0] convResult;    // Last completed result
    // Software registers
    logic        fastRateQ;     // Turbo conversion mode
    logic        chainModeQ;    // Interface mode latched at start
    // Serial output sequencer
    sasr_so_state_t stateQ;
    sasr_so_state_t stateD;
    logic [14:0] shRegQ;        // Bit 14 drives the pin
    logic [14:0] shRegD;
    logic [3:0]  bitCntQ;       // Falls seen in this frame
    logic [3:0]  bitCntD;
    logic        oeQ;
    logic        oeD;
    logic        busy4wQ;       // Busy frame released by cascade high
    logic        busy4wD;
    logic        selActive;     // Host selects us in select mode
    logic        selPrevQ;
    logic        selStart;
    // Bus slave
    logic        addrTaken;
    logic        wrPendQ;
    logic [7:0]  wrAddrQ;
    logic [31:0] rdMux;
    logic        modeErr;
    logic [31:0] statusWord;

    // Every host pin passes four flops before use
    sasr_sync #(
        .W (3)
    ) uSync (
        .clk     (clk),
        .srst    (srst),
        .asyncIn ({pinsIn.shiftClk, pinsIn.cascade, pinsIn.strobe}),
        .level   (pinLvl),
        .rise    (pinRise),
        .fall    (pinFall)
    );

    assign strobeLvl  = pinLvl[PIN_STROBE];
    assign strobeRise = pinRise[PIN_STROBE];
    assign cascLvl    = pinLvl[PIN_CASC];
    assign sckFall    = pinFall[PIN_SCK];

    // Conversion timer and result store
    sasr_convert uConv (
        .clk      (clk),
        .srst     (srst),
        .start    (strobeRise),
        .fastRate (fastRateQ),
        .sampleIn (sampleIn),
        .busy     (convActive),
        .done     (convDone),
        .result   (convResult)
    );

    // A rise during a running conversion starts nothing
    assign convStart = strobeRise && !convActive;

    // Previous cascade level for the mode decision
    always_ff @(posedge clk) begin
        if (srst) begin
            cascPrevQ <= 1'b1;
        end else begin
            cascPrevQ <= cascLvl;
        end
    end

    // Mode is taken from the level before the edge; a cascade wired
    // to the strobe rises in the same cycle and so still reads low
    always_ff @(posedge clk) begin
        if (srst) begin
            chainModeQ <= 1'b0;
        end else if (convStart) begin
            chainModeQ <= !cascPrevQ;
        end
    end

    // Select-mode read select: strobe low (3-wire) or cascade low (4-wire)
    assign selActive = !strobeLvl || !cascLvl;
    assign selStart  = selActive && !selPrevQ;

    // Edge memory; starts set so leaving reset is not a select edge
    always_ff @(posedge clk) begin
        if (srst) begin
            selPrevQ <= 1'b1;
        end else begin
            selPrevQ <= selActive;
        end
    end

    // Next state of the serial output
    always_comb begin
        stateD  = stateQ;
        shRegD  = shRegQ;
        bitCntD = bitCntQ;
        oeD     = oeQ;
        busy4wD = busy4wQ;
        if (strobeRise) begin
            // Release the pin; keep the bit count so a split read resumes
            stateD = SO_IDLE;
            oeD    = 1'b0;
        end else if (convDone) begin
            // New result: any half-read frame is void
            bitCntD = 4'h0;
            if (chainModeQ) begin
                if (fastRateQ) begin
                    // Chain is not offered in turbo, stay released
                    stateD = SO_IDLE;
                    oeD    = 1'b0;
                end else begin
                    stateD = SO_CHAIN;
                    shRegD = {convResult, 1'b0};
                    oeD    = !strobeLvl;
                end
            end else if (selActive && !fastRateQ) begin
                // Busy start bit: pin goes from released to driven
                stateD  = SO_BUSY;
                shRegD  = {BUSY_START, convResult};
                oeD     = 1'b1;
                busy4wD = !cascLvl;
            end else begin
                stateD = SO_IDLE;
                oeD    = 1'b0;
            end
        end else begin
            case (stateQ)
                SO_IDLE: begin
                    // Acquisition reads in turbo need a fresh select edge
                    if (!chainModeQ && selStart) begin
                        stateD = SO_SEL;
                        oeD    = 1'b1;
                        if (bitCntQ == 4'h0) begin
                            // Fresh frame: MSB of the stored result
                            shRegD = {convResult, 1'b0};
                        end
                        // Otherwise a split read carries on where it was
                    end
                end
                SO_SEL: begin
                    if (!selActive) begin
                        stateD = SO_IDLE;
                        oeD    = 1'b0;
                    end else if (sckFall) begin
                        shRegD = {shRegQ[13:0], 1'b0};
                        if (bitCntQ == 4'(SHIFT_BITS - 1)) begin
                            stateD  = SO_IDLE;
                            oeD     = 1'b0;
                            bitCntD = 4'h0;
                        end else begin
                            bitCntD = bitCntQ + 4'h1;
                        end
                    end
                end
                SO_BUSY: begin
                    if (busy4wQ && cascLvl) begin
                        // 4-wire busy frame ends when cascade goes high
                        stateD  = SO_IDLE;
                        oeD     = 1'b0;
                        bitCntD = 4'h0;
                    end else if (sckFall) begin
                        shRegD = {shRegQ[13:0], 1'b0};
                        if (bitCntQ == 4'(BUSY_BITS - 1)) begin
                            stateD  = SO_IDLE;
                            oeD     = 1'b0;
                            bitCntD = 4'h0;
                        end else begin
                            bitCntD = bitCntQ + 4'h1;
                        end
                    end
                end
                SO_CHAIN: begin
                    // Shift register behaviour: cascade bits follow ours
                    oeD = !strobeLvl;
                    if (sckFall && !strobeLvl) begin
                        shRegD = {shRegQ[13:1], cascLvl, 1'b0};
                    end
                end
                default: begin
                    stateD = SO_IDLE;
                    oeD    = 1'b0;
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (srst) begin
            stateQ  <= SO_IDLE;
            shRegQ  <= 15'h0000;
            bitCntQ <= 4'h0;
            oeQ     <= 1'b0;
            busy4wQ <= 1'b0;
        end else begin
            stateQ  <= stateD;
            shRegQ  <= shRegD;
            bitCntQ <= bitCntD;
            oeQ     <= oeD;
            busy4wQ <= busy4wD;
        end
    end

    // Pin register, so the pad sees no combinational glitches
    always_ff @(posedge clk) begin
        if (srst) begin
            sdoOut <= '0;
        end else begin
            sdoOut.oe   <= oeD;
            sdoOut.data <= shRegD[14];
        end
    end

    // Bus slave: zero wait states, always OKAY
    assign addrTaken = hsel && htrans[1] && hready;

    // Write address phase is held for the data phase
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPendQ <= 1'b0;
            wrAddrQ <= 8'h00;
        end else begin
            wrPendQ <= addrTaken && hwrite && (hsize == HSIZE_WORD)
                       && (haddr[31:8] == 24'h000000);
            if (addrTaken) begin
                wrAddrQ <= haddr[7:0];
            end
        end
    end

    // Control register steers conversion length and mode checks
    always_ff @(posedge clk) begin
        if (srst) begin
            fastRateQ <= CTRL_FAST_RST;
        end else if (wrPendQ && wrAddrQ == REG_CTRL) begin
            fastRateQ <= hwdata[CTRL_FAST_BIT];
        end
    end

    // Chain latched while in turbo cannot deliver data
    assign modeErr = chainModeQ && fastRateQ;

    // Status view of the block's own state
    always_comb begin
        statusWord = 32'h00000000;
        statusWord[STS_CHAIN_BIT] = chainModeQ;
        statusWord[STS_BUSY_BIT]  = (stateQ == SO_BUSY);
        statusWord[STS_CONV_BIT]  = convActive;
        statusWord[STS_MERR_BIT]  = modeErr;
        statusWord[STS_ACQ_BIT]   = !fastRateQ;
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        rdMux = 32'h00000000;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                REG_CTRL:   rdMux[CTRL_FAST_BIT] = fastRateQ;
                REG_STATUS: rdMux = statusWord;
                REG_RESULT: rdMux[RES_W-1:0] = convResult;
                default:    rdMux = 32'h00000000;
            endcase
        end
    end

    // Read data registered at the address phase edge
    always_ff @(posedge clk) begin
        if (srst) begin
            hrdata <= 32'h00000000;
        end else if (addrTaken && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    // Response lines never stall and never error
    always_ff @(posedge clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_mode_latch: assert property (
        convStart |=> chainModeQ == !$past(cascPrevQ))
        else $error("interface mode not taken from cascade level");

    chk_tied_chain: assert property (
        convStart && cascLvl && !cascPrevQ |=> chainModeQ)
        else $error("tied cascade did not give chain mode");

    chk_chain_turbo: assert property (
        convDone && chainModeQ && fastRateQ |=> !sdoOut.oe [*2])
        else $error("chain output driven in turbo mode");

    chk_chain_shift: assert property (
        stateQ == SO_CHAIN && sckFall && !strobeLvl && !strobeRise
        && !convDone |=> shRegQ[1] == $past(cascLvl))
        else $error("cascade bit not shifted into chain");

    chk_busy_start: assert property (
        convDone && !chainModeQ && selActive && !fastRateQ && !strobeRise
        |=> stateQ == SO_BUSY && sdoOut.oe && sdoOut.data == BUSY_START)
        else $error("busy start bit not driven at completion");

    chk_busy_turbo: assert property (
        convDone && fastRateQ |=> stateQ != SO_BUSY)
        else $error("busy start bit armed in turbo mode");

    chk_conv_hold: assert property (
        convActive && strobeRise |=> convActive || convDone)
        else $error("conversion disturbed by strobe rise");

    chk_sel_end: assert property (
        stateQ == SO_SEL && sckFall && selActive && !strobeRise
        && !convDone && bitCntQ == 4'(SHIFT_BITS - 1)
        |=> !sdoOut.oe && bitCntQ == 4'h0)
        else $error("output not released after last bit");

    chk_sel_msb: assert property (
        stateQ == SO_IDLE && !chainModeQ && selStart && bitCntQ == 4'h0
        && !strobeRise && !convDone
        |=> sdoOut.oe && sdoOut.data == $past(convResult[RES_W-1]))
        else $error("frame did not open with the result MSB");

    chk_strobe_hiz: assert property (
        strobeRise |=> !sdoOut.oe ##1 stateQ != SO_SEL)
        else $error("output still driven after strobe rise");

    chk_split_resume: assert property (
        stateQ == SO_IDLE && !chainModeQ && selStart && bitCntQ != 4'h0
        && !strobeRise && !convDone
        |=> sdoOut.oe && bitCntQ == $past(bitCntQ))
        else $error("split read did not resume at its bit");
endmodule

// ===== hw/sasr_sync.sv
`timescale 1ns/10ps
module sasr_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] asyncIn,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    // Three stages; only the second and third are compared
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : gBit
            // Chain of three flops per pin
            always_ff @(posedge clk) begin
                if (srst) begin
                    s1Q[i] <= 1'b0;
                    s2Q[i] <= 1'b0;
                    s3Q[i] <= 1'b0;
                end else begin
                    s1Q[i] <= asyncIn[i];
                    s2Q[i] <= s1Q[i];
                    s3Q[i] <= s2Q[i];
                end
            end
            // A change counts once stages two and three agree
            always_ff @(posedge clk) begin
                if (srst) begin
                    level[i] <= 1'b0;
                    rise[i]  <= 1'b0;
                    fall[i]  <= 1'b0;
                end else begin
                    rise[i] <= (s2Q[i] == s3Q[i]) && s3Q[i] && !level[i];
                    fall[i] <= (s2Q[i] == s3Q[i]) && !s3Q[i] && level[i];
                    if (s2Q[i] == s3Q[i]) begin
                        level[i] <= s3Q[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// ===== verification/sar_adc_serial_readout_tb_top.sv
`timescale 1ns/10ps
module sar_adc_serial_readout_tb_top;
    import sasr_pkg::*;
    logic        clk;        // 125 MHz clock
    logic        srst;       // Synchronous reset
    logic        hsel;       // Bus select
    logic [31:0] haddr;      // Bus address
    logic [1:0]  htrans;     // Transfer type
    logic        hwrite;     // Write flag
    logic [2:0]  hsize;      // Transfer size
    logic [31:0] hwdata;     // Write data
    logic [31:0] hrdata;     // Read data
    logic        hready;     // Ready of the one slave
    logic        hresp;      // Response
    logic [13:0] sampleIn;   // Core value to convert
    logic        convActive; // Conversion running
    sasr_pins_t  pins;       // Host pins
    sasr_sdo_t   sdoOut;     // Serial output pin
    logic [31:0] rd;         // Last read word
    logic [31:0] seed;       // Random state
    logic [15:0] b;          // Bits read back
    logic [15:0] c;          // First burst of a split read
    logic [13:0] v1;         // Sample values
    logic [13:0] v2;
    logic [13:0] v3;
    int          nMismatch;
    int          nChecks;

    sasr_readout sasr_readout_inst (.clk(clk), .srst(srst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .pinsIn(pins),
        .sampleIn(sampleIn), .sdoOut(sdoOut), .convActive(convActive));
    sasr_host sasr_host_inst (.clk(clk), .sdoOut(sdoOut), .pins(pins));

    // Clock: 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Shift-register random source
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Status word expected for a mode and conversion speed
    function automatic logic [31:0] stsExp(input logic ch, input logic f);
        stsExp = 32'h0;
        stsExp[STS_CHAIN_BIT] = ch;
        stsExp[STS_MERR_BIT] = ch & f;
        stsExp[STS_ACQ_BIT] = ~f;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One single-word transfer; waits on ready, no fixed latency
    task automatic ahb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rdat = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog; the sequence needs under 2000 cycles
    initial begin
        repeat (5000) @(posedge clk);
        nMismatch++;
        close_out();
    end

    initial begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        sampleIn = 14'h0;
        nMismatch = 0;
        nChecks = 0;
        seed = 32'hDDF1;
        repeat (3) @(posedge clk);
        chk({31'h0, hready}, 32'h1);
        srst <= 1'b0;
        // Reset values, then an unmapped place
        ahb(1'b0, REG_CTRL, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, stsExp(1'b0, 1'b0));
        ahb(1'b1, 8'h0C, 32'hFFFFFFFF, rd);
        ahb(1'b0, 8'h0C, 32'h0, rd);
        chk(rd, 32'h0);
        // Select mode, strobe held high through the conversion
        seed = lfsr(seed);
        v1 = seed[13:0];
        sampleIn <= v1;
        sasr_host_inst.convert(1'b1, 1'b0);
        chk({31'h0, convActive}, 32'h1);
        repeat (60) @(posedge clk);
        chk({31'h0, convActive}, 32'h0);
        // Split read: 11 bits in acquisition, 3 in the next conversion
        sasr_host_inst.setStrobe(1'b0);
        sasr_host_inst.readBits(11, 16'hFFFF, c);
        seed = lfsr(seed);
        v2 = seed[13:0];
        sampleIn <= v2;
        sasr_host_inst.convert(1'b1, 1'b0);
        chk({31'h0, sdoOut.oe}, 32'h0);
        sasr_host_inst.setStrobe(1'b0);
        sasr_host_inst.readBits(3, 16'hFFFF, b);
        chk({18'h0, c[10:0], b[2:0]}, {18'h0, v1});
        repeat (6) @(posedge clk);
        chk({31'h0, sdoOut.oe}, 32'h0);
        // Strobe low at the end arms the start bit
        for (int t = 0; t < 100 && sdoOut.oe !== 1'b1; t++) @(posedge clk);
        sasr_host_inst.readBits(15, 16'hFFFF, b);
        chk({17'h0, b[14:0]}, {17'h0, BUSY_START, v2});
        repeat (6) @(posedge clk);
        chk({31'h0, sdoOut.oe}, 32'h0);
        ahb(1'b0, REG_RESULT, 32'h0, rd);
        chk(rd, {18'h0, v2});
        // 4-wire busy frame: strobe stays high, cascade low selects
        seed = lfsr(seed);
        v1 = seed[13:0];
        sampleIn <= v1;
        sasr_host_inst.convert(1'b1, 1'b0);
        // Strobe is already high, so this only lowers the cascade
        sasr_host_inst.convert(1'b0, 1'b0);
        for (int t = 0; t < 100 && convActive !== 1'b0; t++) @(posedge clk);
        sasr_host_inst.readBits(8, 16'h0000, b);
        chk({24'h0, b[7:0]}, {24'h0, BUSY_START, v1[13:7]});
        // Cascade back high ends the frame before its last bit
        sasr_host_inst.convert(1'b1, 1'b0);
        chk({31'h0, sdoOut.oe}, 32'h0);
        sasr_host_inst.setStrobe(1'b0);
        // Chain mode, select tied to the strobe
        seed = lfsr(seed);
        v3 = seed[13:0];
        sampleIn <= v3;
        sasr_host_inst.convert(1'b0, 1'b1);
        repeat (60) @(posedge clk);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, stsExp(1'b1, 1'b0));
        sasr_host_inst.setStrobe(1'b0);
        sasr_host_inst.readBits(16, seed[31:16], b);
        chk({16'h0, b}, {16'h0, v3, seed[16], seed[17]});
        // Turbo refuses chain mode
        ahb(1'b1, REG_CTRL, 32'h1, rd);
        ahb(1'b0, REG_CTRL, 32'h0, rd);
        chk(rd, 32'h1);
        sasr_host_inst.convert(1'b0, 1'b0);
        repeat (60) @(posedge clk);
        ahb(1'b0, REG_STATUS, 32'h0, rd);
        chk(rd, stsExp(1'b1, 1'b1));
        sasr_host_inst.setStrobe(1'b0);
        repeat (10) @(posedge clk);
        chk({31'h0, sdoOut.oe}, 32'h0);
        close_out();
    end
endmodule

// ===== verification/sasr_host.sv
`timescale 1ns/10ps
module sasr_host (
    input  wire logic                clk,
    input  wire sasr_pkg::sasr_sdo_t sdoOut,
    output sasr_pkg::sasr_pins_t     pins
);
    import sasr_pkg::*;
    logic sdoLine; // Wire level; pull-up shows while the pin is released
    assign sdoLine = sdoOut.oe ? sdoOut.data : 1'b1;
    // Idle: strobe low, select high, shift clock parked low
    initial pins = 3'h2;
    // Pause so the sampler sees each level; keeps strobe edges quiet
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Strobe level; low selects the part for readback
    task automatic setStrobe(input logic lvl);
        @(posedge clk);
        pins.strobe <= lvl;
        hold(4);
    endtask
    // Start a conversion, mode given by the select level before the edge
    task automatic convert(input logic casc, input logic tie);
        @(posedge clk);
        pins.cascade <= casc;
        hold(4);
        pins.strobe <= 1'b1;
        if (tie) begin
            pins.cascade <= 1'b1;
        end
        hold(6);
    endtask
    // Clock n bits with a gated shift clock, sampling before each fall
    task automatic readBits(input int n, input logic [15:0] pat,
                            output logic [15:0] bits);
        bits = 16'h0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            pins.shiftClk <= 1'b1;
            pins.cascade  <= pat[i];
            hold(5);
            bits = {bits[14:0], sdoLine};
            pins.shiftClk <= 1'b0;
            hold(4);
        end
    endtask
endmodule
